//--- pkg/strap_mux_map.svh
// How it works
// - Reset low forces all channel logic to defaults and holds it there.
// - Autoconfig selector pins captured at reset release choose stored configuration.
// - After reset autoconfig pins become general I/O zero and one.
// - Factory test strap sampled at reset release; high enters factory test.
// - After reset factory test pin becomes general I/O two.
// - Interface bit zero sampled at reset release, combined with bit one.
// - After reset interface bit zero pin becomes active-low SPI select input.
// - Interface bit one sampled at reset release to set interface mode.
// - After reset interface bit one pin becomes SPI read data output.
`ifndef STRAP_MUX_MAP_SVH
`define STRAP_MUX_MAP_SVH
`define RST_MIN_LOW_NS 100
`define CLK_PERIOD_NS 40
`define GPIO_COUNT 3
`define AC_WIDTH 2
`define IF_WIDTH 2
`define STRAP_RESET_VAL 1'b0
`define GPIO_IDX_TEST 2
`endif

//--- pkg/strap_mux_pkg.sv
package strap_mux_pkg;
  typedef enum logic [1:0] {
    st_reset,
    st_capture,
    st_run
  } phase_t;
  typedef logic [1:0] iface_mode_t;
endpackage

//--- pkg/strap_bus_if.sv
`timescale 1ns/10ps
interface strap_bus_if;
  logic capture;
  logic run;
  modport ctrl (output capture, output run);
  modport user (input capture, input run);
endinterface

//--- core/strap_phase.sv
`timescale 1ns/10ps
`include "strap_mux_map.svh"
module strap_phase (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  strap_bus_if.ctrl bus
);
  strap_mux_pkg::phase_t phase_q;
  strap_mux_pkg::phase_t phase_d;

  // The first clock after release samples the straps, then the pins change role.
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      strap_mux_pkg::st_reset: phase_d = strap_mux_pkg::st_capture;
      strap_mux_pkg::st_capture: phase_d = strap_mux_pkg::st_run;
      strap_mux_pkg::st_run: phase_d = strap_mux_pkg::st_run;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= strap_mux_pkg::st_reset;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign bus.capture = (phase_q == strap_mux_pkg::st_reset);
  assign bus.run = (phase_q == strap_mux_pkg::st_run);
endmodule // strap_phase

//--- core/reset_strap_pin_function_mux.sv
`timescale 1ns/10ps
`include "strap_mux_map.svh"
module reset_strap_pin_function_mux #(
  parameter int GPIO_N = `GPIO_COUNT
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] autoconfig_select_i,
  input wire logic test_pin_i,
  input wire logic iface_mode_bit_zero_i,
  input wire logic iface_mode_bit_one_i,
  input wire logic [GPIO_N-1:0] pin_io_config_dir_i,
  input wire logic [GPIO_N-1:0] pin_io_config_out_i,
  input wire logic spi_read_data_i,
  input wire logic spi_read_active_i,
  output logic [GPIO_N-1:0] gpio_out_o,
  output logic [GPIO_N-1:0] gpio_oe_o,
  output logic [GPIO_N-1:0] pin_io_state_o,
  output logic [1:0] autoconfig_sel_o,
  output logic factory_test_o,
  output logic [1:0] iface_mode_o,
  output logic spi_select_low_o,
  output logic miso_out_o,
  output logic miso_oe_o,
  output logic straps_valid_o
);
  // One channel's shared pins. While the reset is low every register below sits at its
  // default and no pin is driven. The first clock after the reset rises takes the straps:
  // the two configuration selector pins, the factory test pin and both interface mode
  // pins. From the third clock on the pins take their run roles: the selector and test
  // pins become general I/O zero to two, interface bit zero becomes the active-low serial
  // select and interface bit one becomes the serial read data output.
  // The straps are reported on dedicated outputs and never move again until reset.
  // The minimum reset width is the board's duty; the logic accepts any width, since an
  // asynchronous reset clears everything at once.
  // Every pin-side output is registered, so all run roles lag their inputs by a clock.

  // Only the three shared general I/O pins exist; any other count has no pins to serve.
  if (GPIO_N != `GPIO_COUNT) begin : gen_gpio_n_check
    $error("GPIO_N must equal the number of shared general I/O pins");
  end

  // The sequencer walks reset, capture and run. The capture step is the first clock after
  // release, so the straps are sampled synchronously; a pin that moves within one clock of
  // the reset edge may be taken either way, which the board must avoid.
  strap_bus_if bus ();

  strap_phase u_phase (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .bus(bus)
  );

  // Pin levels of the shared pins, ordered as the general I/O numbers.
  logic [GPIO_N-1:0] pins_in;

  // Captured straps.
  logic [`AC_WIDTH-1:0] ac_q;
  logic [`AC_WIDTH-1:0] ac_d;
  logic test_q;
  logic test_d;
  strap_mux_pkg::iface_mode_t if_q;
  strap_mux_pkg::iface_mode_t if_d;

  // Marks that the straps above have been taken since the last reset.
  logic valid_q;
  logic valid_d;

  // General I/O drive, enable and reported state.
  logic [GPIO_N-1:0] gout_q;
  logic [GPIO_N-1:0] gout_d;
  logic [GPIO_N-1:0] goe_q;
  logic [GPIO_N-1:0] goe_d;
  logic [GPIO_N-1:0] gst_q;
  logic [GPIO_N-1:0] gst_d;

  // Serial select and read data pins.
  logic csn_q;
  logic csn_d;
  logic miso_q;
  logic miso_d;
  logic misooe_q;
  logic misooe_d;

  assign pins_in = {test_pin_i, autoconfig_select_i};

  // Straps are taken by a clocked process after release, never by the reset itself.
  // Once taken they stay put whatever the pins do, until the reset falls again.
  always_comb begin
    ac_d = ac_q;
    test_d = test_q;
    if_d = if_q;
    if (bus.capture) begin
      ac_d = autoconfig_select_i;
      test_d = test_pin_i;
      if_d = {iface_mode_bit_one_i, iface_mode_bit_zero_i};
    end
  end

  // Reset returns the straps to the values of a normal start.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ac_q <= '0;
      test_q <= `STRAP_RESET_VAL;
      if_q <= '0;
    end else begin
      ac_q <= ac_d;
      test_q <= test_d;
      if_q <= if_d;
    end
  end

  // The flag rises with the capture and falls only with reset.
  always_comb begin
    valid_d = valid_q;
    if (bus.capture) begin
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  // General I/O: nothing is driven before the run phase, so a strap resistor never
  // fights the chip while the straps are being sampled. The reported state is the
  // driven value for an output and the pin level for an input.
  for (genvar g = 0; g < GPIO_N; g++) begin : gen_gpio
    always_comb begin
      gout_d[g] = 1'b0;
      goe_d[g] = 1'b0;
      gst_d[g] = 1'b0;
      if (bus.run) begin
        gout_d[g] = pin_io_config_out_i[g];
        goe_d[g] = pin_io_config_dir_i[g];
        if (pin_io_config_dir_i[g]) begin
          gst_d[g] = pin_io_config_out_i[g];
        end else begin
          gst_d[g] = pins_in[g];
        end
      end
    end
  end

  // All general I/O state is cleared by reset, so the pins float to their straps.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gout_q <= '0;
      goe_q <= '0;
      gst_q <= '0;
    end else begin
      gout_q <= gout_d;
      goe_q <= goe_d;
      gst_q <= gst_d;
    end
  end

  // The select reads high (idle) outside the run phase, so no access can start
  // while the pin still serves as a strap.
  always_comb begin
    csn_d = 1'b1;
    if (bus.run) begin
      csn_d = iface_mode_bit_zero_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      csn_q <= 1'b1;
    end else begin
      csn_q <= csn_d;
    end
  end

  // Read data is enabled only while a read is active and the select pin is low, so
  // the pin is released as soon as the master deselects. The enable follows the
  // select by one clock, a limitation the master must allow for.
  always_comb begin
    miso_d = 1'b0;
    misooe_d = 1'b0;
    if (bus.run) begin
      miso_d = spi_read_data_i;
      misooe_d = spi_read_active_i & ~iface_mode_bit_zero_i;
    end
  end

  // The read data pin is released during reset so it can act as a strap again.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso_q <= 1'b0;
      misooe_q <= 1'b0;
    end else begin
      miso_q <= miso_d;
      misooe_q <= misooe_d;
    end
  end

  // Every output is a register; these only rename them.
  assign autoconfig_sel_o = ac_q;
  assign factory_test_o = test_q;
  assign iface_mode_o = if_q;
  assign straps_valid_o = valid_q;
  assign gpio_out_o = gout_q;
  assign gpio_oe_o = goe_q;
  assign pin_io_state_o = gst_q;
  assign spi_select_low_o = csn_q;
  assign miso_out_o = miso_q;
  assign miso_oe_o = misooe_q;
endmodule // reset_strap_pin_function_mux

//--- dv/strap_board_model.sv
`timescale 1ns/10ps
module strap_board_model (
  input wire logic test_i,
  input wire logic acc_i,
  output logic test_o,
  output logic select_low_o
);
  // The test strap stays low unless a scenario asks for factory test.
  assign test_o = test_i;
  assign select_low_o = ~acc_i;
endmodule // strap_board_model

//--- dv/reset_strap_pin_function_mux_chk.sv
`timescale 1ns/10ps
module reset_strap_pin_function_mux_chk (
  input wire logic ref_clk_i, nrst_i, test_pin_i, iface_mode_bit_zero_i, iface_mode_bit_one_i,
  input wire logic spi_read_active_i, factory_test_o, spi_select_low_o, miso_oe_o, straps_valid_o,
  input wire logic [1:0] autoconfig_select_i, autoconfig_sel_o, iface_mode_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_cap; $rose(straps_valid_o); endsequence
  sequence s_run; $past(straps_valid_o, 2); endsequence
  property p_sv; !straps_valid_o |=> straps_valid_o; endproperty
  a_sv: assert property (p_sv) else $error("late capture");
  property p_cap; s_cap |-> {autoconfig_sel_o, factory_test_o, iface_mode_o} ==
    $past({autoconfig_select_i, test_pin_i, iface_mode_bit_one_i, iface_mode_bit_zero_i}); endproperty
  a_cap: assert property (p_cap) else $error("strap capture");
  property p_hd; straps_valid_o |=> $stable({autoconfig_sel_o, factory_test_o, iface_mode_o}); endproperty
  a_hd: assert property (p_hd) else $error("strap changed");
  property p_df; !straps_valid_o |-> spi_select_low_o && !miso_oe_o; endproperty
  a_df: assert property (p_df) else $error("not default");
  property p_cs; s_run |-> spi_select_low_o == $past(iface_mode_bit_zero_i); endproperty
  a_cs: assert property (p_cs) else $error("select");
  property p_mi; miso_oe_o |-> straps_valid_o && $past(spi_read_active_i); endproperty
  a_mi: assert property (p_mi) else $error("miso enable");
endmodule // reset_strap_pin_function_mux_chk
bind reset_strap_pin_function_mux reset_strap_pin_function_mux_chk i_chk (.*);

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk = 0, nrst = 0, tst = 0, acc = 0, if1 = 0, rd = 0, rdat = 0, tp, if0, ft, csl, mo, moe, vl;
  logic [1:0] ac = 0, aco, md;
  logic [2:0] dir = 0, dout = 0, go, goe, st;
  int errors = 0;
  int checks = 0;
  strap_board_model i_strap_board_model (.test_i(tst), .acc_i(acc), .test_o(tp), .select_low_o(if0));
  reset_strap_pin_function_mux i_reset_strap_pin_function_mux (.ref_clk_i(clk), .nrst_i(nrst),
    .autoconfig_select_i(ac), .test_pin_i(tp), .iface_mode_bit_zero_i(if0), .iface_mode_bit_one_i(if1),
    .pin_io_config_dir_i(dir), .pin_io_config_out_i(dout), .spi_read_data_i(rdat), .spi_read_active_i(rd),
    .gpio_out_o(go), .gpio_oe_o(goe), .pin_io_state_o(st), .autoconfig_sel_o(aco), .factory_test_o(ft),
    .iface_mode_o(md), .spi_select_low_o(csl), .miso_out_o(mo), .miso_oe_o(moe), .straps_valid_o(vl));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Pins are flipped after release so a strap latch that follows its pin is caught.
  task automatic t_straps(input logic [4:0] v);
    @(negedge clk);
    nrst = 0;
    {tst, if1, acc, ac} = v ^ 5'h04;
    repeat (8) @(negedge clk);
    check({vl, csl, moe, ft, md, aco}, 9'h040, "reset");
    check({goe, go, st}, 9'h000, "reset gpio");
    nrst = 1;
    repeat (3) @(negedge clk);
    check({vl, ft, md, aco}, {1'b1, v}, "straps");
    {tst, if1, acc, ac} = ~v ^ 5'h04;
    repeat (2) @(negedge clk);
    check({ft, md, aco}, v, "held");
  endtask
  task automatic t_run();
    {tst, acc, rd, ac, dir, dout} = 11'h1af;
    repeat (2) @(negedge clk);
    check({goe, go, st}, 9'h17f, "gpio");
    check({csl, moe, mo}, 9'h004, "idle");
    acc = 1;
    rdat = 1;
    repeat (3) @(negedge clk);
    check({csl, moe, mo}, 9'h003, "read");
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
  initial begin
    for (int i = 27; i >= 0; i -= 9) begin
      t_straps(5'(i));
    end
    t_run();
    give_verdict();
  end
endmodule // testbench
